// ==== rtl/rcs_pkg.sv ====
// Purpose: constants and types shared by the reset control and status block
// Assumes: register map on a 32-bit AXI4-Lite slave, one aligned word per register
// Notes: the lockup count is expressed in oscillator periods of the reference clock
package rcs_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_WD_STATUS = 8'h00;
  localparam logic [7:0] OFF_PROT_CMD = 8'h04;
  localparam logic [7:0] OFF_SYS_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_CLK_CTRL = 8'h14;
  localparam logic [7:0] OFF_RST_STATE = 8'h18;
  // field positions
  localparam int WD_FLAG_BIT = 0;
  localparam int PROT_ERR_BIT = 0;
  localparam int IRQ_WDT_BIT = 0;
  localparam int IRQ_PERR_BIT = 1;
  localparam int IRQ_DBG_BIT = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [7:0] WD_STATUS_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // byte-only write strobe for the watchdog status register
  localparam logic [3:0] STRB_BYTE0 = 4'h1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // clock selection codes
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X1P25 = 2'h1;
  localparam logic [1:0] DIV_NONE = 2'h0;
  // timing: lockup of 2^14 oscillator periods, reference clock taken as one per period
  localparam int LOCKUP_OSC_PERIODS = 16384;
  localparam int REF_CYCLES_PER_OSC = 1;
  localparam int LOCKUP_CYCLES = LOCKUP_OSC_PERIODS * REF_CYCLES_PER_OSC;
  localparam int WDT_HOLD_CYCLES = 16;

  typedef struct packed {
    logic [1:0] mult;
    logic [1:0] div;
  } rcs_clk_cfg_type;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_LOCKUP,
    ST_RUN
  } rcs_state_type;
endpackage : rcs_pkg

// ==== rtl/rcs_reset_ctrl.sv ====
// Purpose: reset source merge, lockup sequencing and watchdog reset status
// Assumes: single 50 MHz clock i_ref_clk, synchronous active-high i_rst
// Notes: registers reached over AXI4-Lite; one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_ctrl #(
  parameter int LOCKUP_CYCLES = rcs_pkg::LOCKUP_CYCLES,
  parameter int WDT_HOLD_CYCLES = rcs_pkg::WDT_HOLD_CYCLES,
  parameter int CNT_W = 24
) (
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst, // synchronous reset, active high
  input wire logic i_reset_pin_n, // external reset pin, asynchronous
  input wire logic i_pll_mode, // clock mode strap pin, 1 = PLL
  input wire logic i_wdt_overflow, // watchdog overflow pulse
  input wire logic i_dbg_force_reset, // debug unit forced reset level
  input wire logic i_dbg_reset_mask, // debug unit reset mask level
  input wire logic [7:0] i_awaddr, // write address
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // write byte strobes
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  output logic [1:0] o_bresp, // write response
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  input wire logic [7:0] i_araddr, // read address
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output logic o_rvalid, // read data valid
  input wire logic i_rready, // read data ready
  output logic o_periph_reset, // peripheral reset, active high
  output logic o_cpu_run, // CPU may fetch and execute
  output logic o_osc_run, // oscillator and clock supply running
  output rcs_pkg::rcs_clk_cfg_type o_clk_cfg, // clock multiplier and divider
  output logic o_irq // level interrupt
);
  import rcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic pin_s1_q, pin_s2_q, pll_s1_q, pll_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= i_reset_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pll_s1_q <= 1'b0;
      pll_q <= 1'b0;
    end else begin
      pll_s1_q <= i_pll_mode;
      pll_q <= pll_s1_q;
    end
  end

  // the mask covers the pin and watchdog; a forced reset from debug always acts
  logic pin_rst, wdt_evt, dbg_evt;
  assign pin_rst = !pin_s2_q && !i_dbg_reset_mask;
  assign wdt_evt = i_wdt_overflow && !i_dbg_reset_mask;
  assign dbg_evt = i_dbg_force_reset;

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer
  rcs_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_HOLD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (!pin_rst && !dbg_evt) begin
          // no oscillation wait here: the pin's low width must cover it
          state_d = ST_LOCKUP;
          cnt_d = CNT_W'(LOCKUP_CYCLES - 1);
        end
      end
      ST_LOCKUP: begin
        if (cnt_q == '0) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
    if (pin_rst || dbg_evt) begin
      state_d = ST_HOLD;
      cnt_d = '0;
    end else if (wdt_evt) begin
      // watchdog reset times itself out without any outside action
      state_d = ST_HOLD;
      cnt_d = CNT_W'(WDT_HOLD_CYCLES - 1);
    end
  end

  logic periph_rst_q, cpu_run_q, osc_run_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= ST_HOLD;
      cnt_q <= '0;
      periph_rst_q <= 1'b1;
      cpu_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      // peripherals held, debug unit and RAM are not reached by this reset
      periph_rst_q <= (state_d == ST_HOLD);
      cpu_run_q <= (state_d == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock settings
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic wr_fire, clk_wr;
  rcs_clk_cfg_type clk_cfg_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      clk_cfg_q <= '{mult: MULT_X1, div: DIV_NONE};
      osc_run_q <= 1'b1;
    end else begin
      if (state_d == ST_HOLD) begin
        clk_cfg_q.mult <= pll_q ? MULT_X1P25 : MULT_X1;
        clk_cfg_q.div <= DIV_NONE;
      end else if (clk_wr) begin
        clk_cfg_q <= wr_data_q[3:0];
      end
      osc_run_q <= !(pll_q && state_d == ST_HOLD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic aw_hold_q, w_hold_q, bvalid_q;
  logic [7:0] wr_addr_q;
  logic [1:0] bresp_q;
  assign o_awready = !aw_hold_q && !bvalid_q;
  assign o_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_q <= 1'b1;
        wr_addr_q <= {i_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_hold_q <= 1'b1;
        wr_data_q <= i_wdata;
        wr_strb_q <= i_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  logic sel_wd, sel_cmd, sel_sys, sel_ist, sel_msk, sel_clk, sel_st, wr_known;
  assign sel_wd = (wr_addr_q == OFF_WD_STATUS);
  assign sel_cmd = (wr_addr_q == OFF_PROT_CMD);
  assign sel_sys = (wr_addr_q == OFF_SYS_STATUS);
  assign sel_ist = (wr_addr_q == OFF_IRQ_STATUS);
  assign sel_msk = (wr_addr_q == OFF_IRQ_MASK);
  assign sel_clk = (wr_addr_q == OFF_CLK_CTRL);
  assign sel_st = (wr_addr_q == OFF_RST_STATE);
  assign wr_known = sel_wd || sel_cmd || sel_sys || sel_ist || sel_msk || sel_clk || sel_st;
  assign clk_wr = wr_fire && sel_clk && wr_strb_q[0];

  logic wd_bad_size, prot_armed_q, wd_legal, wd_illegal;
  assign wd_bad_size = sel_wd && (wr_strb_q != STRB_BYTE0);
  // the armed state lasts exactly one write: any other write in between disarms
  assign wd_legal = wr_fire && sel_wd && !wd_bad_size && prot_armed_q;
  assign wd_illegal = wr_fire && sel_wd && !wd_bad_size && !prot_armed_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prot_armed_q <= 1'b0;
    end else if (wr_fire) begin
      prot_armed_q <= sel_cmd;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (!wr_known || wd_bad_size) ? RESP_SLVERR : RESP_OKAY;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog reset status and protect error
  logic wd_flag_q, prot_err_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wd_flag_q <= WD_STATUS_RST[WD_FLAG_BIT];
    end else if (pin_rst) begin
      wd_flag_q <= 1'b0;
    end else if (wdt_evt) begin
      // set beats a clearing write in the same cycle
      wd_flag_q <= 1'b1;
    end else if (wd_legal && !wr_data_q[WD_FLAG_BIT]) begin
      wd_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prot_err_q <= 1'b0;
    end else if (wd_illegal) begin
      prot_err_q <= 1'b1;
    end else if (wr_fire && sel_sys && wr_strb_q[0] && !wr_data_q[PROT_ERR_BIT]) begin
      prot_err_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic irq_q;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_WDT_BIT] = wdt_evt;
    irq_set[IRQ_PERR_BIT] = wd_illegal;
    irq_set[IRQ_DBG_BIT] = dbg_evt && !periph_rst_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      if (wr_fire && sel_ist && wr_strb_q[0]) begin
        irq_stat_q <= (irq_stat_q & ~wr_data_q[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      if (wr_fire && sel_msk && wr_strb_q[0]) begin
        irq_mask_q <= wr_data_q[IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic rvalid_q;
  logic [31:0] rdata_q, rd_mux;
  logic [1:0] rresp_q;
  logic [7:0] rd_addr;
  logic rd_wd_q;
  assign o_arready = !rvalid_q;
  assign rd_addr = {i_araddr[7:2], 2'b00};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_addr)
      OFF_WD_STATUS: rd_mux[WD_FLAG_BIT] = wd_flag_q;
      OFF_PROT_CMD: rd_mux = 32'h0000_0000;
      OFF_SYS_STATUS: rd_mux[PROT_ERR_BIT] = prot_err_q;
      OFF_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_stat_q;
      OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      OFF_CLK_CTRL: rd_mux[3:0] = clk_cfg_q;
      OFF_RST_STATE: rd_mux[4:0] = {state_q, osc_run_q, cpu_run_q, periph_rst_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      rd_wd_q <= 1'b0;
    end else if (i_arvalid && o_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rd_wd_q <= (rd_addr == OFF_WD_STATUS);
      rresp_q <= (rd_addr > OFF_RST_STATE) ? RESP_SLVERR : RESP_OKAY;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_periph_reset = periph_rst_q;
  assign o_cpu_run = cpu_run_q;
  assign o_osc_run = osc_run_q;
  assign o_clk_cfg = clk_cfg_q;
  assign o_irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CNT_W-1:0] lk_cnt_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || state_q != ST_LOCKUP) begin
      lk_cnt_q <= '0;
    end else begin
      lk_cnt_q <= lk_cnt_q + 1'b1;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_pin_enters_reset: assert property (pin_rst |=> o_periph_reset && !o_cpu_run)
    else $error("pin reset did not hold the device");
  a_wdt_enters_reset: assert property (wdt_evt |=> o_periph_reset[*2])
    else $error("watchdog reset did not hold the device");
  a_dbg_forces_reset: assert property (dbg_evt |=> o_periph_reset)
    else $error("debug forced reset ignored");
  a_wide_write_refused: assert property (wr_fire && wd_bad_size |=> o_bresp == RESP_SLVERR && $stable(wd_flag_q) || $past(wdt_evt) || $past(pin_rst))
    else $error("non-byte status write not refused");
  a_unprot_write_err: assert property (wd_illegal |=> prot_err_q && $stable(wd_flag_q) || $past(wdt_evt) || $past(pin_rst))
    else $error("unprotected status write not flagged");
  a_pin_clears_flag: assert property (pin_rst |=> !wd_flag_q)
    else $error("pin reset left the status flag set");
  a_wdt_sets_flag: assert property (wdt_evt && !pin_rst |=> wd_flag_q)
    else $error("watchdog reset did not set the flag");
  a_flag_no_sw_set: assert property (!wd_flag_q && !wdt_evt |=> !wd_flag_q)
    else $error("status flag set without watchdog reset");
  a_pin_release: assert property (state_q == ST_HOLD && cnt_q == '0 && !pin_rst && !dbg_evt && !wdt_evt |=> state_q == ST_LOCKUP && !o_periph_reset)
    else $error("reset not released on pin rise");
  a_lockup_elapse: assert property (state_q == ST_LOCKUP && state_d == ST_RUN |-> lk_cnt_q == CNT_W'(LOCKUP_CYCLES - 1) ##1 o_cpu_run)
    else $error("CPU started before lockup time");
  a_clk_x1_mode: assert property (o_periph_reset && !$past(pll_q) |-> o_clk_cfg.mult == MULT_X1 && o_clk_cfg.div == DIV_NONE && o_osc_run)
    else $error("clock-through reset settings wrong");
  a_clk_pll_mode: assert property (o_periph_reset && $past(pll_q) |-> o_clk_cfg.mult == MULT_X1P25 && o_clk_cfg.div == DIV_NONE && !o_osc_run)
    else $error("PLL reset settings wrong");
  a_cpu_held: assert property (o_periph_reset |-> !o_cpu_run)
    else $error("CPU running during reset");
  a_high_bits_zero: assert property (o_rvalid && rd_wd_q |-> o_rdata[31:1] == 31'h0)
    else $error("status high bits not zero");

  c_pin_cycle: cover property (pin_rst ##1 !pin_rst [*1] ##[1:100] state_q == ST_LOCKUP);
  c_wdt_cycle: cover property (wdt_evt ##[1:40] state_q == ST_LOCKUP);
  c_legal_clear: cover property (wd_flag_q ##[1:50] (wd_legal && !wr_data_q[0]));
  c_prot_error: cover property (wd_illegal ##1 o_irq [*1]);
endmodule : rcs_reset_ctrl
`default_nettype wire

// ==== test/rcs_ext_src.sv ====
// Purpose: model of the reset pin driver and the watchdog overflow source
// Assumes: bench raises i_press to pull the pin and i_fire to request one overflow
// Notes: pin stays low for a minimum width even if the request is short
`timescale 1ns/1ps
`default_nettype none
module rcs_ext_src #(
  parameter int MIN_LOW = 4
) (
  input wire logic i_clk, // system clock
  input wire logic i_press, // request to hold the pin low
  input wire logic i_fire, // request one overflow pulse
  output logic o_reset_pin_n, // reset pin, active low
  output logic o_wdt_overflow // overflow pulse, one cycle
);
  int low_cnt;
  logic fire_q;
  initial begin
    o_reset_pin_n = 1'b1;
    o_wdt_overflow = 1'b0;
    low_cnt = 0;
    fire_q = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // a short press would not cover oscillator start, so the width is padded
  always @(posedge i_clk) begin
    if (i_press || (low_cnt > 0 && low_cnt < MIN_LOW)) begin
      o_reset_pin_n <= 1'b0;
      low_cnt <= low_cnt + 1;
    end else begin
      o_reset_pin_n <= 1'b1;
      low_cnt <= 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    fire_q <= i_fire;
    o_wdt_overflow <= i_fire && !fire_q;
  end
endmodule : rcs_ext_src
`default_nettype wire

// ==== test/rcs_reset_ctrl_tb_top.sv ====
// Purpose: self-checking bench for the reset control and status block
// Assumes: short lockup and watchdog hold counts set through parameters
// Notes: expected values come from the package constants and the bench's own counts
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_ctrl_tb_top;
  import rcs_pkg::*;
  localparam int LK = 8;
  localparam int WH = 2;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [3:0] s;
    logic [1:0] resp;
    logic [31:0] rd;
  } rcs_row_type;
  logic i_ref_clk, i_rst, i_pll_mode, i_dbg_force_reset, i_dbg_reset_mask, press, fire;
  logic pin_n, wdt_ovf, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, o_irq;
  logic o_periph_reset, o_cpu_run, o_osc_run;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rdat;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, resp;
  rcs_clk_cfg_type o_clk_cfg;
  int fails, n_tests, t;
  rcs_row_type rows [9] = '{
    '{1'b0, OFF_WD_STATUS, 32'h0, 4'h0, RESP_OKAY, 32'h0},
    '{1'b0, OFF_PROT_CMD, 32'h0, 4'h0, RESP_OKAY, 32'h0},
    '{1'b0, OFF_IRQ_MASK, 32'h0, 4'h0, RESP_OKAY, 32'h0},
    '{1'b0, OFF_CLK_CTRL, 32'h0, 4'h0, RESP_OKAY, 32'h0},
    '{1'b0, OFF_RST_STATE, 32'h0, 4'h0, RESP_OKAY, 32'h16},
    '{1'b0, 8'h1C, 32'h0, 4'h0, RESP_SLVERR, 32'h0},
    '{1'b1, 8'h1C, 32'hFF, 4'hF, RESP_SLVERR, 32'h0},
    '{1'b1, OFF_CLK_CTRL, 32'h5, 4'h1, RESP_OKAY, 32'h0},
    '{1'b0, OFF_CLK_CTRL, 32'h0, 4'h0, RESP_OKAY, 32'h5}};

  rcs_ext_src #(.MIN_LOW(4)) ext (.i_clk(i_ref_clk), .i_press(press), .i_fire(fire),
    .o_reset_pin_n(pin_n), .o_wdt_overflow(wdt_ovf));
  rcs_reset_ctrl #(.LOCKUP_CYCLES(LK), .WDT_HOLD_CYCLES(WH), .CNT_W(24)) dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reset_pin_n(pin_n), .i_pll_mode(i_pll_mode),
    .i_wdt_overflow(wdt_ovf), .i_dbg_force_reset(i_dbg_force_reset),
    .i_dbg_reset_mask(i_dbg_reset_mask), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_periph_reset(o_periph_reset), .o_cpu_run(o_cpu_run), .o_osc_run(o_osc_run),
    .o_clk_cfg(o_clk_cfg), .o_irq(o_irq));

  always #10 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tick

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // address and data offered together, each released once taken
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    r = 2'h3;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (n < 50) begin
      tick(1);
      n++;
      if (aw_ok && w_ok && o_bvalid === 1'b1) begin
        r = o_bresp;
        n = 99;
      end
      if (!aw_ok && o_awready === 1'b1) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_ok && o_wready === 1'b1) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    check("write_answered", n, 99);
    i_bready <= 1'b0;
    tick(1);
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_ok;
    n = 0;
    ar_ok = 1'b0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (n < 50) begin
      tick(1);
      n++;
      if (ar_ok && o_rvalid === 1'b1) begin
        d = o_rdata;
        r = o_rresp;
        n = 99;
      end
      if (!ar_ok && o_arready === 1'b1) begin
        ar_ok = 1'b1;
        i_arvalid <= 1'b0;
      end
    end
    check("read_answered", n, 99);
    i_rready <= 1'b0;
    tick(1);
  endtask : bus_read

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    bus_read(a, rdat, resp);
    check("reg_value", rdat, exp);
  endtask : expect_reg

  task automatic wait_run;
    t = 0;
    while (o_cpu_run !== 1'b1 && t < 200) begin
      tick(1);
      t++;
    end
    check("cpu_run", o_cpu_run, 1'b1);
  endtask : wait_run

  task automatic pulse_wdt;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(2);
  endtask : pulse_wdt
  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(20000);
    fails++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    {i_ref_clk, i_pll_mode, i_dbg_force_reset, i_dbg_reset_mask, press, fire} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    fails = 0;
    n_tests = 0;
    i_rst = 1'b1;
    tick(10);
    check("periph_in_reset", o_periph_reset, 1'b1);
    check("osc_in_reset", o_osc_run, 1'b1);
    check("cfg_in_reset", o_clk_cfg, {MULT_X1, DIV_NONE});
    i_rst <= 1'b0;
    t = 0;
    while (o_periph_reset !== 1'b0 && t < 100) begin
      tick(1);
      t++;
    end
    t = 0;
    while (o_cpu_run !== 1'b1 && t < 100) begin
      tick(1);
      t++;
    end
    check("lockup_cycles", t, LK);
    $display("test bring_up done");
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        bus_write(rows[i].a, rows[i].d, rows[i].s, resp);
      end else begin
        bus_read(rows[i].a, rdat, resp);
        check("row_rdata", rdat, rows[i].rd);
      end
      check("row_resp", resp, rows[i].resp);
    end
    $display("test register_table done");
    pulse_wdt();
    check("wdt_periph", o_periph_reset, 1'b1);
    check("wdt_cpu", o_cpu_run, 1'b0);
    check("wdt_cfg", o_clk_cfg, {MULT_X1, DIV_NONE});
    check("wdt_osc", o_osc_run, 1'b1);
    wait_run();
    expect_reg(OFF_WD_STATUS, 32'h1);
    expect_reg(OFF_IRQ_STATUS, 32'h1);
    check("irq_masked", o_irq, 1'b0);
    bus_write(OFF_IRQ_MASK, 32'h1, 4'hF, resp);
    tick(2);
    check("irq_raised", o_irq, 1'b1);
    bus_write(OFF_IRQ_STATUS, 32'h1, 4'hF, resp);
    tick(2);
    check("irq_cleared", o_irq, 1'b0);
    $display("test watchdog_reset done");
    bus_write(OFF_WD_STATUS, 32'h0, STRB_BYTE0, resp);
    expect_reg(OFF_WD_STATUS, 32'h1);
    expect_reg(OFF_SYS_STATUS, 32'h1);
    bus_write(OFF_PROT_CMD, 32'hA5, 4'hF, resp);
    bus_write(OFF_WD_STATUS, 32'h0, 4'h3, resp);
    check("half_write_resp", resp, RESP_SLVERR);
    expect_reg(OFF_WD_STATUS, 32'h1);
    bus_write(OFF_PROT_CMD, 32'hA5, 4'hF, resp);
    bus_write(OFF_WD_STATUS, 32'hFF, STRB_BYTE0, resp);
    expect_reg(OFF_WD_STATUS, 32'h1);
    $display("test protection done");
    i_pll_mode <= 1'b1;
    press <= 1'b1;
    tick(4);
    check("sync_delay", o_periph_reset, 1'b0);
    tick(4);
    check("pll_osc_stop", o_osc_run, 1'b0);
    check("pll_cfg", o_clk_cfg, {MULT_X1P25, DIV_NONE});
    check("pin_cpu", o_cpu_run, 1'b0);
    press <= 1'b0;
    wait_run();
    expect_reg(OFF_WD_STATUS, 32'h0);
    expect_reg(OFF_CLK_CTRL, {28'h0, MULT_X1P25, DIV_NONE});
    $display("test pin_reset done");
    pulse_wdt();
    wait_run();
    expect_reg(OFF_WD_STATUS, 32'h1);
    bus_write(OFF_PROT_CMD, 32'hA5, 4'hF, resp);
    bus_write(OFF_WD_STATUS, 32'h0, STRB_BYTE0, resp);
    expect_reg(OFF_WD_STATUS, 32'h0);
    $display("test flag_clear done");
    i_dbg_reset_mask <= 1'b1;
    pulse_wdt();
    tick(3);
    check("masked_wdt", o_periph_reset, 1'b0);
    i_dbg_force_reset <= 1'b1;
    tick(3);
    check("forced_reset", o_periph_reset, 1'b1);
    i_dbg_force_reset <= 1'b0;
    i_dbg_reset_mask <= 1'b0;
    tick(2);
    wait_run();
    expect_reg(OFF_WD_STATUS, 32'h0);
    $display("test debug_reset done");
    finish_test();
  end
endmodule : rcs_reset_ctrl_tb_top
`default_nettype wire
